// >>> texel_map.svh
// Named offsets, field positions, limits and reset values of the decoder.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef TEXEL_MAP_SVH
`define TEXEL_MAP_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_TABLE_BASE  12'h040
`define REG_TABLE_LAST  12'h0BC
`define CTRL_RESET      32'h0000_0001
`define CTRL_ENABLE_BIT 0

// ----------------------------------------------------------------------
// Signed single-channel word layout
// ----------------------------------------------------------------------
`define BASE_HI       63
`define BASE_LO       56
`define MULT_HI       55
`define MULT_LO       52
`define TABLE_HI      51
`define TABLE_LO      48
`define PIX_TOP       47
`define PIX_BITS      3
`define BASE_FORBID   8'h80
`define BASE_SUBST    8'h81
`define LIMIT_POS     16'sh03FF
`define LIMIT_NEG     (-16'sh03FF)
`define SCALE_SHIFT   3
`define VALUE_W       11
`define MAG_W         10

// ----------------------------------------------------------------------
// Four-channel mode-select and field layout
// ----------------------------------------------------------------------
`define RED_HI        63
`define RED_LO        59
`define RDELTA_HI     58
`define RDELTA_LO     56
`define GREEN_HI      55
`define GREEN_LO      51
`define GDELTA_HI     50
`define GDELTA_LO     48
`define BLUE_HI       47
`define BLUE_LO       43
`define BDELTA_HI     42
`define BDELTA_LO     40
`define TCW1_HI       39
`define TCW1_LO       37
`define TCW2_HI       36
`define TCW2_LO       34
`define SOLID_BIT     33
`define FLIP_BIT      32
`define FRED_HI       62
`define FRED_LO       59
`define DIST_HI_BIT   34
`define DIST_LO_BIT   32
`define PIX_MSB_BASE  16
`define PIX_LSB_BASE  0
`define COLOR_MAX     7'sd31

`endif

// >>> texel_pkg.sv
// Types shared by the texel block decoder and its channel datapath.
// Assumes texel_map.svh sits in the include path.
package texel_pkg;

// ----------------------------------------------------------------------
// Formats and modes
// ----------------------------------------------------------------------
typedef enum logic [1:0]
{
    signed_single_channel_format = 2'h0,
    signed_dual_channel_format   = 2'h1,
    cutout_alpha_color_format    = 2'h2
} fmt_e;

// One-hot colour-block modes
typedef enum logic [3:0]
{
    MODE_DIFF   = 4'h1,
    MODE_T      = 4'h2,
    MODE_H      = 4'h4,
    MODE_PLANAR = 4'h8
} mode_e;

// ----------------------------------------------------------------------
// Carriers
// ----------------------------------------------------------------------
typedef struct packed
{
    logic [127:0] block;
    fmt_e         fmt;
    logic [3:0]   texel;
} fetch_req_s;

typedef struct packed
{
    fmt_e              fmt;
    logic [3:0]        texel;
    logic signed [10:0] red;
    logic signed [10:0] green;
} texel_out_s;

typedef struct packed
{
    mode_e      mode;
    logic [4:0] red_base;
    logic [2:0] red_delta;
    logic [4:0] green_base;
    logic [2:0] green_delta;
    logic [4:0] blue_base;
    logic [2:0] blue_delta;
    logic [2:0] table_cw1;
    logic [2:0] table_cw2;
    logic       solid_alpha_flag;
    logic       flip;
    logic [3:0] first_red;
    logic       dist_index_high;
    logic       dist_index_low;
    logic       pix_msb;
    logic       pix_lsb;
} cutout_fields_s;

endpackage

// >>> signed_channel_decoder.sv
// One signed single-channel texel datapath: scale, clamp and extend.
// Assumes the modifier has already been looked up by the caller.
`timescale 1ns/100ps
`include "texel_map.svh"

module signed_channel_decoder
#(
    parameter int EXT_W = 16
)
(
    input  wire logic [7:0]           base_byte,
    input  wire logic [3:0]           multiplier,
    input  wire logic signed [7:0]    modifier,
    output logic signed [10:0]        value11,
    output logic signed [EXT_W-1:0]   value_ext
);
    import texel_pkg::*;

    logic signed [7:0]       base_fix;
    logic signed [15:0]      base_term;
    logic signed [15:0]      prod;
    logic signed [15:0]      mod_term;
    logic signed [15:0]      sum;
    logic [`VALUE_W-1:0]     mag;
    logic [EXT_W-1:0]        rep;

    // Replicate the ten magnitude bits down the wider word, sign bit zero
    function automatic logic [EXT_W-1:0] replicate(input logic [9:0] m);
        logic [EXT_W-1:0] r;
        r = '0;
        for (int i = 0; i < EXT_W - 1; i++)
        begin
            r[EXT_W-2-i] = m[`MAG_W-1-(i % `MAG_W)];
        end
        return r;
    endfunction

    // Base scaling and modifier term
    always_comb
    begin
        base_fix = (base_byte == `BASE_FORBID) ? `BASE_SUBST
                                               : base_byte;
        base_term = 16'(base_fix) <<< `SCALE_SHIFT;
        prod = 16'(modifier) * $signed({12'h000, multiplier});
        if (multiplier == 4'h0)
        begin
            mod_term = 16'(modifier);
        end
        else
        begin
            mod_term = prod <<< `SCALE_SHIFT;
        end
        sum = base_term + mod_term;
        if (sum > `LIMIT_POS)
        begin
            value11 = 11'(`LIMIT_POS);
        end
        else if (sum < `LIMIT_NEG)
        begin
            value11 = 11'(`LIMIT_NEG);
        end
        else
        begin
            value11 = sum[10:0];
        end
    end

    // Negatives are made positive, replicated, then negated back
    always_comb
    begin
        mag = value11[10] ? 11'(-value11) : value11;
        rep = replicate(mag[9:0]);
        value_ext = value11[10] ? EXT_W'(-rep) : rep;
    end

    // EXT_W below the decoded width plus five bits is rejected
    if (EXT_W < `VALUE_W + 5)
    begin : g_bad_width
        $error("extension width too small");
    end

endmodule

// >>> texel_block_decoder.sv
// Compressed texel block decoder with an AHB-Lite register slave.
// Assumes fetch logic and the bus share hclk; requests need no ready.
`timescale 1ns/100ps
`include "texel_map.svh"

module texel_block_decoder
#(
    parameter int EXT_W = 16
)
(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [31:0]                    hrdata,
    output logic                           hresp,
    // Fetch side
    input  wire logic                      req_valid,
    input  wire texel_pkg::fetch_req_s     req,
    // Filter side
    output logic                           out_valid,
    output texel_pkg::texel_out_s          out_texel,
    output logic [EXT_W-1:0]               out_red_ext,
    output logic [EXT_W-1:0]               out_green_ext,
    output texel_pkg::cutout_fields_s      out_cutout
);
    import texel_pkg::*;

    localparam int TABLE_ENTRIES = 128;

    // ------------------------------------------------------------------
    // Register decode helpers
    // ------------------------------------------------------------------

    // Modifier-table window, word aligned
    function automatic logic is_table(input logic [11:0] a);
        return (a >= `REG_TABLE_BASE) && (a <= `REG_TABLE_LAST);
    endfunction

    // First table entry held by a table word
    function automatic logic [6:0] table_index(input logic [11:0] a);
        logic [11:0] off;
        off = a - `REG_TABLE_BASE;
        return {off[6:2], 2'b00};
    endfunction

    // Assemble a 64-bit word with the lowest-address byte most significant
    function automatic logic [63:0] byte_word(input logic [63:0] b);
        logic [63:0] w;
        for (int k = 0; k < 8; k++)
        begin
            w[63-8*k -: 8] = b[8*k +: 8];
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------------
    logic [31:0]  ctrl;
    logic [31:0]  next_ctrl;
    logic [15:0]  texel_count;
    logic [15:0]  next_texel_count;
    logic [3:0]   last_mode;
    logic [3:0]   next_last_mode;
    logic         wr_pend;
    logic         next_wr_pend;
    logic [11:0]  wr_addr;
    logic [11:0]  next_wr_addr;
    logic [31:0]  next_hrdata;
    logic [7:0]   mod_table [TABLE_ENTRIES];
    logic [7:0]   next_mod_table [TABLE_ENTRIES];
    logic         addr_phase;
    logic [11:0]  a_off;

    assign addr_phase = hsel && htrans[1] && hready;
    assign a_off      = haddr[11:0];

    // Address phase captures writes; read data prepared for data phase
    always_comb
    begin
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = addr_phase ? a_off : wr_addr;
        next_hrdata  = 32'h0000_0000;
        if (addr_phase && !hwrite)
        begin
            if (a_off == `REG_CTRL)
            begin
                next_hrdata = ctrl;
            end
            else if (a_off == `REG_STATUS)
            begin
                next_hrdata = {12'h000, last_mode, texel_count};
            end
            else if (is_table(a_off))
            begin
                for (int e = 0; e < 4; e++)
                begin
                    next_hrdata[8*e +: 8] =
                        mod_table[table_index(a_off) + 7'(e)];
                end
            end
        end
    end

    // Data-phase write; unmapped writes are dropped
    always_comb
    begin
        next_ctrl = ctrl;
        next_mod_table = mod_table;
        if (wr_pend)
        begin
            if (wr_addr == `REG_CTRL)
            begin
                next_ctrl = hwdata;
            end
            else if (is_table(wr_addr))
            begin
                for (int e = 0; e < 4; e++)
                begin
                    next_mod_table[table_index(wr_addr) + 7'(e)] =
                        hwdata[8*e +: 8];
                end
            end
        end
    end

    // Bus registers; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl      <= `CTRL_RESET;
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            for (int i = 0; i < TABLE_ENTRIES; i++)
            begin
                mod_table[i] <= 8'h00;
            end
        end
        else
        begin
            ctrl      <= next_ctrl;
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            mod_table <= next_mod_table;
        end
    end

    // ------------------------------------------------------------------
    // Signed channel datapath
    // ------------------------------------------------------------------
    logic [63:0]         red_block_word;
    logic [63:0]         green_block_word;
    logic [63:0]         chan_word [2];
    logic signed [10:0]  chan_val  [2];
    logic [EXT_W-1:0]    chan_ext  [2];

    // Byte order of the block in memory fixes the word layout
    assign red_block_word   = byte_word(req.block[63:0]);
    assign green_block_word = byte_word(req.block[127:64]);
    assign chan_word[0]     = red_block_word;
    assign chan_word[1]     = green_block_word;

    // Both channels share one datapath shape
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
        logic [2:0] pix;
        logic [6:0] idx;
        int         top;

        assign top = `PIX_TOP - `PIX_BITS * int'(req.texel);
        assign pix = chan_word[c][top -: `PIX_BITS];
        assign idx = {chan_word[c][`TABLE_HI:`TABLE_LO], pix};

        signed_channel_decoder #(.EXT_W(EXT_W)) u_dec
        (
            .base_byte  (chan_word[c][`BASE_HI:`BASE_LO]),
            .multiplier (chan_word[c][`MULT_HI:`MULT_LO]),
            .modifier   (mod_table[idx]),
            .value11    (chan_val[c]),
            .value_ext  (chan_ext[c])
        );
    end

    // ------------------------------------------------------------------
    // Four-channel mode selection and field split
    // ------------------------------------------------------------------
    cutout_fields_s  fields;
    logic signed [6:0] red_sum;
    logic signed [6:0] green_sum;
    logic signed [6:0] blue_sum;

    // Block word of the cutout format is the first eight bytes
    always_comb
    begin
        fields             = '0;
        fields.red_base    = red_block_word[`RED_HI:`RED_LO];
        fields.red_delta   = red_block_word[`RDELTA_HI:`RDELTA_LO];
        fields.green_base  = red_block_word[`GREEN_HI:`GREEN_LO];
        fields.green_delta = red_block_word[`GDELTA_HI:`GDELTA_LO];
        fields.blue_base   = red_block_word[`BLUE_HI:`BLUE_LO];
        fields.blue_delta  = red_block_word[`BDELTA_HI:`BDELTA_LO];
        // Unsigned bases, signed deltas
        red_sum   = $signed({2'b00, fields.red_base})
                  + 7'($signed(fields.red_delta));
        green_sum = $signed({2'b00, fields.green_base})
                  + 7'($signed(fields.green_delta));
        blue_sum  = $signed({2'b00, fields.blue_base})
                  + 7'($signed(fields.blue_delta));
        if (red_sum < 0 || red_sum > `COLOR_MAX)
        begin
            fields.mode = MODE_T;
        end
        else if (green_sum < 0 || green_sum > `COLOR_MAX)
        begin
            fields.mode = MODE_H;
        end
        else if (blue_sum < 0 || blue_sum > `COLOR_MAX)
        begin
            fields.mode = MODE_PLANAR;
        end
        else
        begin
            fields.mode = MODE_DIFF;
        end
        // One word covers a whole 4x4 RGBA block
        fields.table_cw1 = red_block_word[`TCW1_HI:`TCW1_LO];
        fields.table_cw2 = red_block_word[`TCW2_HI:`TCW2_LO];
        fields.solid_alpha_flag = red_block_word[`SOLID_BIT];
        fields.flip      = red_block_word[`FLIP_BIT];
        fields.first_red = red_block_word[`FRED_HI:`FRED_LO];
        fields.dist_index_high = red_block_word[`DIST_HI_BIT];
        fields.dist_index_low  = red_block_word[`DIST_LO_BIT];
        // Planar blocks carry no per-texel index
        if (fields.mode != MODE_PLANAR)
        begin
            fields.pix_msb =
                red_block_word[`PIX_MSB_BASE + int'(req.texel)];
            fields.pix_lsb =
                red_block_word[`PIX_LSB_BASE + int'(req.texel)];
        end
    end

    // ------------------------------------------------------------------
    // Result stage
    // ------------------------------------------------------------------
    logic            accept;
    logic            next_out_valid;
    texel_out_s      next_out_texel;
    logic [EXT_W-1:0] next_red_ext;
    logic [EXT_W-1:0] next_green_ext;
    cutout_fields_s  next_cutout;

    // Requests are dropped while the enable bit is clear
    assign accept = req_valid && ctrl[`CTRL_ENABLE_BIT];

    // Results held until the next accepted request
    always_comb
    begin
        next_out_valid   = accept;
        next_out_texel   = out_texel;
        next_red_ext     = out_red_ext;
        next_green_ext   = out_green_ext;
        next_cutout      = out_cutout;
        next_texel_count = texel_count;
        next_last_mode   = last_mode;
        if (accept)
        begin
            next_out_texel.fmt   = req.fmt;
            next_out_texel.texel = req.texel;
            next_out_texel.red   = 11'sh000;
            next_out_texel.green = 11'sh000;
            next_red_ext         = '0;
            next_green_ext       = '0;
            next_cutout          = '0;
            next_texel_count     = texel_count + 16'h0001;
            if (req.fmt == cutout_alpha_color_format)
            begin
                next_cutout    = fields;
                next_last_mode = fields.mode;
            end
            else
            begin
                next_out_texel.red = chan_val[0];
                next_red_ext       = chan_ext[0];
                if (req.fmt == signed_dual_channel_format)
                begin
                    next_out_texel.green = chan_val[1];
                    next_green_ext       = chan_ext[1];
                end
            end
        end
    end

    // Result and status registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_valid     <= 1'b0;
            out_texel     <= '0;
            out_red_ext   <= '0;
            out_green_ext <= '0;
            out_cutout    <= '0;
            texel_count   <= 16'h0000;
            last_mode     <= 4'h0;
        end
        else
        begin
            out_valid     <= next_out_valid;
            out_texel     <= next_out_texel;
            out_red_ext   <= next_red_ext;
            out_green_ext <= next_green_ext;
            out_cutout    <= next_cutout;
            texel_count   <= next_texel_count;
            last_mode     <= next_last_mode;
        end
    end

endmodule

// >>> texel_block_decoder_assertions.sv
// Checker for the decoder's result and bus response ports.
// Assumes a bind into every texel_block_decoder instance.
`timescale 1ns/100ps
module texel_block_decoder_assertions
#(
    parameter int EXT_W = 16
)
(
    input wire logic                      hclk,
    input wire logic                      hresetn,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    input wire logic                      req_valid,
    input wire logic                      out_valid,
    input wire texel_pkg::texel_out_s     out_texel,
    input wire logic [EXT_W-1:0]          out_red_ext,
    input wire logic [EXT_W-1:0]          out_green_ext,
    input wire texel_pkg::cutout_fields_s out_cutout
);
    import texel_pkg::*;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Replication widening; magnitude first so the sign never replicates
    function automatic logic [15:0] ext16(input logic signed [10:0] v);
        logic [10:0] m;
        m = v[10] ? 11'(-v) : v;
        ext16 = {m, 5'h00} + {10'h000, m[10:5]};
        if (v[10])
            ext16 = -ext16;
    endfunction

    // Mode priority: red, then green, then blue out of range
    function automatic mode_e pick(input cutout_fields_s c);
        int r;
        int g;
        int b;
        r = int'(c.red_base) + int'($signed(c.red_delta));
        g = int'(c.green_base) + int'($signed(c.green_delta));
        b = int'(c.blue_base) + int'($signed(c.blue_delta));
        if (r < 0 || r > 31)
            pick = MODE_T;
        else if (g < 0 || g > 31)
            pick = MODE_H;
        else if (b < 0 || b > 31)
            pick = MODE_PLANAR;
        else
            pick = MODE_DIFF;
    endfunction

    ready_always_a: assert property (hreadyout)
        else $error("hreadyout dropped");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    valid_after_req_a: assert property (out_valid |->
        $past(req_valid))
        else $error("out_valid without a request");
    hold_result_a: assert property (!req_valid |=> $stable(out_texel))
        else $error("result changed without request");
    clamp_range_a: assert property (out_valid |->
        out_texel.red != 11'h400 && out_texel.green != 11'h400)
        else $error("value outside clamp range");
    ext_pos_a: assert property (out_valid && !out_texel.red[10] |->
        out_red_ext[15:0] == ext16(out_texel.red))
        else $error("positive widening wrong");
    ext_neg_a: assert property (out_valid && out_texel.red[10] |->
        out_red_ext[15:0] == ext16(out_texel.red))
        else $error("negative widening wrong");
    green_ext_a: assert property (out_valid |->
        out_green_ext[15:0] == ext16(out_texel.green))
        else $error("green widening wrong");
    mode_pick_a: assert property (out_valid &&
        out_texel.fmt == cutout_alpha_color_format |->
        out_cutout.mode == pick(out_cutout))
        else $error("mode selection wrong");
    green_zero_a: assert property (out_valid &&
        out_texel.fmt != signed_dual_channel_format |-> out_texel.green == '0)
        else $error("green set outside dual format");
endmodule

bind texel_block_decoder texel_block_decoder_assertions #(.EXT_W(EXT_W)) chk_i
(
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .req_valid     (req_valid),
    .out_valid     (out_valid),
    .out_texel     (out_texel),
    .out_red_ext   (out_red_ext),
    .out_green_ext (out_green_ext),
    .out_cutout    (out_cutout)
);

// >>> fetch_model.sv
// Fetch-side model: one request strobe per send call.
// Assumes the caller leaves a clock edge between sends.
`timescale 1ns/100ps
module fetch_model
(
    input  wire logic             hclk,
    output logic                  req_valid,
    output texel_pkg::fetch_req_s req
);
    import texel_pkg::*;

    // Idle at time zero
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end

    // Released fields flip so stale data never looks valid
    task automatic send(input fetch_req_s r);
        @(posedge hclk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge hclk);
        req_valid <= 1'b0;
        req <= fetch_req_s'(~r);
    endtask
endmodule

// >>> texel_block_decoder_tb.sv
// Self-checking bench for the texel block decoder.
// Assumes the bound checker and the fetch model.
`timescale 1ns/100ps
`include "texel_map.svh"
module texel_block_decoder_tb;
    import texel_pkg::*;
    logic           hclk;
    logic           hresetn;
    logic           hsel;
    logic [31:0]    haddr;
    logic [1:0]     htrans;
    logic           hwrite;
    logic [2:0]     hsize;
    logic [31:0]    hwdata;
    logic           hreadyout;
    logic [31:0]    hrdata;
    logic           hresp;
    logic           req_valid;
    fetch_req_s     req;
    logic           out_valid;
    texel_out_s     out_texel;
    logic [15:0]    red_ext;
    logic [15:0]    green_ext;
    cutout_fields_s cut;
    int             fail_count;
    int             compares;

    fetch_model fetch_model_i (.hclk(hclk), .req_valid(req_valid),
        .req(req));
    texel_block_decoder texel_block_decoder_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .req_valid(req_valid), .req(req),
        .out_valid(out_valid), .out_texel(out_texel),
        .out_red_ext(red_ext), .out_green_ext(green_ext),
        .out_cutout(cut));

    // 20 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic summarize();
        $display("mismatches %0d, compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Single AHB transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a, d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // Byte 0 of each word is its most significant byte
    function automatic logic [127:0] blk(input logic [63:0] w0, w1);
        for (int k = 0; k < 8; k++)
        begin
            blk[8*k +: 8] = w0[63-8*k -: 8];
            blk[64+8*k +: 8] = w1[63-8*k -: 8];
        end
    endfunction

    function automatic logic [63:0] cw(input logic [4:0] r, input
        logic [2:0] dr, input logic [4:0] g, input logic [2:0] dg,
        input logic [4:0] b, input logic [2:0] db, input logic [39:0] lo);
        cw = {r, dr, g, dg, b, db, lo};
    endfunction

    // Result must be valid at the very next edge
    task automatic go(input logic [63:0] w0, w1, input fmt_e f,
        input logic [3:0] t);
        fetch_model_i.send('{blk(w0, w1), f, t});
        @(posedge hclk);
        check(32'(out_valid), 32'h1);
        check(32'({out_texel.fmt, out_texel.texel}), 32'({f, t}));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic regs_test();
        rd(`REG_CTRL, 32'h1);
        wr(`REG_TABLE_BASE + 12'h068, 32'hF6FDFEFF);
        wr(`REG_TABLE_BASE + 12'h06C, 32'h09020100);
        rd(`REG_TABLE_BASE + 12'h068, 32'hF6FDFEFF);
        rd(32'h800, 32'h0);
    endtask

    task automatic signed_test();
        go(64'h3C0D_0C00_0000_0000, '0, signed_single_channel_format, 1);
        check(32'(out_texel.red), 32'd470);
        check(32'(red_ext), 32'd15054);
        go(64'h800D_0000_0000_0000, '0, signed_single_channel_format, 0);
        check(32'(out_texel.red), 32'(-1017));
        check(32'(red_ext), 32'h80C1);
        go(64'h80FD_0C00_0000_0000, '0, signed_single_channel_format, 1);
        check(32'(out_texel.red), 32'(-1023));
        check(32'(red_ext), 32'h8001);
        go(64'h3C0D_0C00_0000_0000, 64'h800D_0000_0000_0000,
            signed_dual_channel_format, 0);
        check(32'(out_texel.red), 32'd479);
        check(32'(out_texel.green), 32'(-1017));
        check(32'(green_ext), 32'h80C1);
    endtask

    task automatic refuse_test();
        wr(`REG_CTRL, 32'h0);
        fetch_model_i.send('{'0, signed_single_channel_format, 4'h0});
        @(posedge hclk);
        check(32'(out_valid), 32'h0);
        wr(`REG_CTRL, 32'h1);
    endtask

    // T, H, planar, then differential at the red boundary 28+3
    task automatic cutout_test();
        logic [63:0] w[4];
        mode_e       m[4];
        w = '{cw(0, 4, 10, 0, 10, 0, 40'h0), cw(11, 0, 0, 7, 10, 0,
            {8'h05, 32'h0}), cw(10, 0, 10, 0, 31, 3, 40'h0),
            cw(28, 3, 10, 0, 10, 0, 40'hAE_0001_8000)};
        m = '{MODE_T, MODE_H, MODE_PLANAR, MODE_DIFF};
        for (int i = 0; i < 4; i++)
        begin
            go(w[i], '0, cutout_alpha_color_format, 0);
            check(32'(cut.mode), 32'(m[i]));
            if (i == 1)
                check({cut.first_red, cut.dist_index_high,
                    cut.solid_alpha_flag, cut.dist_index_low},
                    32'h5D);
        end
        check({cut.red_base, cut.red_delta}, {5'd28, 3'd3});
        check({cut.table_cw1, cut.table_cw2, cut.solid_alpha_flag,
            cut.flip, cut.pix_msb, cut.pix_lsb}, 32'h2BA);
        go(w[3], '0, cutout_alpha_color_format, 15);
        check({cut.pix_msb, cut.pix_lsb}, 32'h1);
        rd(`REG_STATUS, 32'h0001_0009);
    endtask

    // Reset, then the scenarios in turn
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        regs_test();
        signed_test();
        refuse_test();
        cutout_test();
        summarize();
    end

    // Cuts a hang short well past the expected run time
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule
